// *** dv/io_switch_group_control_properties.sv ***
// Checker: bus handshake and pad output relations of the switch bank.
// Assumes a bind to the top module, one clock and a synchronous reset.
`timescale 1ns/10ps
module io_switch_group_control_properties (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic [7:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic [7:0]  THIRD_IO_SWITCH_CLOSED,
	input wire logic [7:0]  THIRD_IO_DRIVE_EN,
	input wire logic [7:0]  THIRD_IO_DRIVE_HIGH,
	input wire logic [7:0]  THIRD_IO_TIMER_CTRL,
	input wire logic [7:0]  THIRD_IO_ELECTRODE,
	input wire logic [7:0]  THIRD_IO_HYST_OFF,
	input wire logic [14:0] ANALOG_SWITCH_CLOSED
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	// Busy on the taken edge, answer on the next edge
	sequence answer_seq;
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence
	// Accepted write to the low analog switch register
	sequence low_write_seq;
		!AVS_WAITREQUEST && AVS_WRITE && AVS_BYTEENABLE[0] && AVS_ADDRESS == 8'h34;
	endsequence
	AST_ANSWER: assert property ($rose(AVS_READ || AVS_WRITE) |-> answer_seq)
		else $error("request not answered on the next edge");
	AST_ONE_CYCLE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer held longer than one cycle");
	AST_LOW_SWITCH: assert property (low_write_seq |-> ##2
		ANALOG_SWITCH_CLOSED[7:0] == $past(AVS_WRITEDATA[7:0], 2))
		else $error("low analog switches do not follow the write");
	AST_NO_SWITCH: assert property (ANALOG_SWITCH_CLOSED[13:12] == 2'h0)
		else $error("absent analog switch closed");
	AST_HIGH_RSVD: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == 8'h38
		|-> (AVS_READDATA[7:0] & 8'hb0) == 8'h00)
		else $error("reserved high switch bits read set");
	AST_READ_UPPER: assert property (!AVS_WAITREQUEST && AVS_READ |-> AVS_READDATA[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	AST_HIGH_DRIVEN: assert property ((THIRD_IO_DRIVE_HIGH & ~THIRD_IO_DRIVE_EN) == 8'h0)
		else $error("high level without push-pull drive");
	AST_TIMER_EXCL: assert property ((THIRD_IO_TIMER_CTRL & (THIRD_IO_DRIVE_EN | THIRD_IO_SWITCH_CLOSED)) == 8'h0)
		else $error("timer pad also forced");
	AST_ELECTRODE: assert property ((THIRD_IO_ELECTRODE & ~THIRD_IO_TIMER_CTRL) == 8'h0)
		else $error("electrode role without timer control");
	AST_HYST_CLOSED: assert property ((THIRD_IO_HYST_OFF & ~THIRD_IO_SWITCH_CLOSED) == 8'h0)
		else $error("hysteresis off with switch open");
endmodule : io_switch_group_control_properties
bind io_switch_group_control io_switch_group_control_properties i_io_switch_group_control_properties (.*);

// *** dv/io_switch_group_control_test.sv ***
// Testbench: register access and pad mode checks of the switch bank.
// Assumes byte address = register index * 4 and a 10 MHz clock.
`timescale 1ns/10ps
module io_switch_group_control_test;
	logic        clock = 1'b0;
	logic        rst, read, write;
	logic [7:0]  address;
	logic [31:0] wdata, rdata;
	logic [3:0]  ben;
	logic        waitreq, acq_hw;
	logic [7:0]  closed, drv_en, drv_high, timer, electrode, hyst, prot, fields, pad;
	logic [14:0] analog;
	int          num_errors = 0;
	int          cmp_count = 0;
	io_switch_group_control i_io_switch_group_control (.CLOCK(clock), .RST(rst),
		.AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(ben), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.THIRD_IO_SWITCH_CLOSED(closed), .THIRD_IO_DRIVE_EN(drv_en),
		.THIRD_IO_DRIVE_HIGH(drv_high), .THIRD_IO_TIMER_CTRL(timer),
		.THIRD_IO_ELECTRODE(electrode), .THIRD_IO_HYST_OFF(hyst), .THIRD_IO_PROTECTED(prot),
		.GROUP_MODE_FIELDS(fields), .ACQUISITION_HW(acq_hw), .ANALOG_SWITCH_CLOSED(analog));
	pad_model i_pad_model (.clock(clock), .drive_en(drv_en), .drive_high(drv_high),
		.pad_level(pad));
	// Clock of 100 ns period
	initial begin
		forever #50 clock = ~clock;
	end
	// One bus cycle, held until waitrequest is sampled low
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
		output logic [31:0] got);
		int n;
		n = 0;
		@(posedge clock);
		address <= addr;
		wdata <= {24'h0, data};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		got = rdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 20) num_errors++;
	endtask : access
	// Compare and count
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] got;
		access(1'b0, addr, 8'h00, got);
		check("register", exp, got);
	endtask : rd
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [31:0] got;
		access(1'b1, addr, data, got);
	endtask : wr
	// Verdict and end of run
	task automatic results;
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	// Cuts a hang short
	initial begin
		repeat (5000) @(posedge clock);
		num_errors++;
		results;
	end
	// Main sequence
	initial begin
		logic [7:0] en, hi, cl;
		rst = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00; wdata = 32'h0; ben = 4'h1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd(8'h2c, 32'h00);
		rd(8'h30, 32'hff);
		rd(8'h34, 32'h00);
		rd(8'h38, 32'h00);
		wr(8'h34, 8'ha5);
		wr(8'h38, 8'hff);
		rd(8'h38, 32'h4f);
		repeat (3) @(posedge clock);
		check("analog", 32'h4fa5, {17'h0, analog});
		ben <= 4'h0;
		wr(8'h34, 8'h77);
		ben <= 4'h1;
		rd(8'h34, 32'ha5);
		wr(8'h34, 8'h00);
		wr(8'h3c, 8'hff);
		rd(8'h3c, 32'h00);
		// Unprotected pads: switch bit alone, mode field ignored
		wr(8'h2c, 8'h0f);
		repeat (3) @(posedge clock);
		check("closed", 32'h0f, {24'h0, closed});
		check("hyst", 32'h00, {24'h0, hyst});
		check("drive", 32'h00, {24'h0, drv_en});
		// Protected, software managed: every field code
		wr(8'h20, 8'hff);
		rd(8'h20, 32'hff);
		wr(8'h2c, 8'hf0);
		repeat (3) @(posedge clock);
		check("protected", 32'hff, {24'h0, prot});
		for (int c = 0; c < 4; c++) begin
			wr(8'h30, {2'h0, c[1:0], 4'h0});
			rd(8'h30, {26'h0, c[1:0], 4'h0});
			repeat (3) @(posedge clock);
			en = (c < 2) ? 8'hff : 8'h0f;
			hi = (c == 1) ? 8'hf0 : 8'h00;
			cl = (c == 3) ? 8'hf0 : 8'h00;
			check("drive", {24'h0, en}, {24'h0, drv_en});
			check("high", {24'h0, hi}, {24'h0, drv_high});
			check("closed", {24'h0, cl}, {24'h0, closed});
			check("hyst", {24'h0, cl}, {24'h0, hyst});
			check("pad", {24'h0, hi}, {24'h0, pad & en});
			check("fields", {24'h0, 2'h0, c[1:0], 4'h0}, {24'h0, fields});
		end
		// Hardware managed: sampling and electrode roles
		wr(8'h80, 8'hff);
		rd(8'h80, 32'h04);
		for (int c = 0; c < 2; c++) begin
			wr(8'h30, {2'h0, c[1:0], 4'h0});
			repeat (3) @(posedge clock);
			check("timer", 32'hf0, {24'h0, timer});
			check("drive", 32'h0f, {24'h0, drv_en});
			check("role", (c == 1) ? 32'hf0 : 32'h00, {24'h0, electrode});
			check("acq", 32'h1, {31'h0, acq_hw});
		end
		results;
	end
endmodule : io_switch_group_control_test

// *** dv/pad_model.sv ***
// Pad model: level seen on each third I/O pad from the block's drive controls.
// Assumes no pull resistors, so a released pad shows the inverse of its last level.
`timescale 1ns/10ps
module pad_model (
	input  wire logic       clock,
	input  wire logic [7:0] drive_en,
	input  wire logic [7:0] drive_high,
	output logic      [7:0] pad_level
);
	logic [7:0] last_r = 8'h00; // Last level of each pad
	// Remember the level so a released pad keeps changing
	always_ff @(posedge clock) begin
		last_r <= pad_level;
	end
	// Driven pads follow the drive level, released pads toggle
	always_comb begin
		pad_level = (drive_en & drive_high) | (~drive_en & ~last_r);
	end
endmodule : pad_model

// *** logic/io_switch_group_control.sv ***
// Top: Avalon-MM register bank for third-I/O switches, group modes and analog switches.
// Assumes a 10 MHz single clock, synchronous active-high reset, and pads outside.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
// Function
// - Third-I/O switch register, 0x0B, reset zero
// - Unprotected: bit closes switch, channel enabled
// - Protected software: 0 low, 1 field
// - Protected hardware: 0 low, 1 timer
// - Group mode register 0x0C, reset 0xFF
// - Field codes: low, high, float open/closed
// - Float closed disables hysteresis, still readable
// - Field applies only to protected I/O
// - Hardware: 00 sampling, 01 electrode
// - Fourth field, hardware usage: low-density only
// - Analog switch low register 0x0D
// - Analog switch high register 0x0E mapping
// - Switches 9-11 absent on medium density
// - Acquisition mode bit 2 at 0x20
// - Control-mode bit selects protected mode
module io_switch_group_control #(
	parameter io_switch_pkg::density_type DENSITY = io_switch_pkg::DENSITY_LOW
) (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic [7:0]       THIRD_IO_SWITCH_CLOSED,
	output logic [7:0]       THIRD_IO_DRIVE_EN,
	output logic [7:0]       THIRD_IO_DRIVE_HIGH,
	output logic [7:0]       THIRD_IO_TIMER_CTRL,
	output logic [7:0]       THIRD_IO_ELECTRODE,
	output logic [7:0]       THIRD_IO_HYST_OFF,
	output logic [7:0]       THIRD_IO_PROTECTED,
	output logic [7:0]       GROUP_MODE_FIELDS,
	output logic             ACQUISITION_HW,
	output logic [14:0]      ANALOG_SWITCH_CLOSED
);
	initial begin
		if (DENSITY > io_switch_pkg::DENSITY_HIGH) $error("Bad density");
	end

	switch_cfg_if cfg ();

	logic [7:0] third_io_switch_r;     // Switch bits of the third I/O
	logic [7:0] io_group_mode_r;       // Group mode fields
	logic [7:0] analog_switch_low_r;   // Switches 7..0
	logic [7:0] analog_switch_high_r;  // Switches 14, 11..8
	logic [7:0] routing_control_r;     // Acquisition mode only
	logic [7:0] protected_mode_bits_r; // Third-I/O control-mode bits
	logic       ack_r;                 // Answer cycle
	logic [31:0] rdata_nxt;            // Read mux
	logic [5:0] idx;                   // Word index
	logic       req;                   // Request pending
	logic       wr_en;                 // Write takes effect
	logic [7:0] wbyte;                 // Low write byte
	logic [7:0] high_mask;             // Implemented high-switch bits
	logic [7:0] mode_mask;             // Implemented group mode bits

	assign idx   = AVS_ADDRESS[7:2];
	assign req   = AVS_READ || AVS_WRITE;
	assign wr_en = AVS_WRITE && ack_r && AVS_BYTEENABLE[0];
	assign wbyte = AVS_WRITEDATA[7:0];
	assign high_mask = (DENSITY == io_switch_pkg::DENSITY_MEDIUM)
		? io_switch_pkg::ANALOG_HIGH_MASK_MED : io_switch_pkg::ANALOG_HIGH_MASK_FULL;
	assign mode_mask = (DENSITY == io_switch_pkg::DENSITY_LOW) ? 8'hff : 8'h3f;

	// Register exposure to the decoder
	assign cfg.third_io_switch     = third_io_switch_r;
	assign cfg.io_group_mode       = io_group_mode_r;
	assign cfg.acquisition_mode    = routing_control_r[io_switch_pkg::ACQUISITION_MODE_BIT];
	assign cfg.protected_mode_bits = protected_mode_bits_r;

	// Waitrequest handshake: one wait cycle, then answer
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= !(req && !ack_r);
		end
	end

	// Third-I/O switch register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			third_io_switch_r <= io_switch_pkg::THIRD_IO_SWITCH_RST;
		end else if (wr_en && idx == io_switch_pkg::THIRD_IO_SWITCH_IDX[5:0]) begin
			third_io_switch_r <= wbyte;
		end
	end
	// Group mode register; fourth field absent off low density
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			io_group_mode_r <= io_switch_pkg::IO_GROUP_MODE_RST & mode_mask;
		end else if (wr_en && idx == io_switch_pkg::IO_GROUP_MODE_IDX[5:0]) begin
			io_group_mode_r <= wbyte & mode_mask;
		end
	end
	// Analog switch low register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			analog_switch_low_r <= io_switch_pkg::ANALOG_SWITCH_LOW_RST;
		end else if (wr_en && idx == io_switch_pkg::ANALOG_SWITCH_LOW_IDX[5:0]) begin
			analog_switch_low_r <= wbyte;
		end
	end
	// Analog switch high register, reserved bits held clear
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			analog_switch_high_r <= io_switch_pkg::ANALOG_SWITCH_HIGH_RST;
		end else if (wr_en && idx == io_switch_pkg::ANALOG_SWITCH_HIGH_IDX[5:0]) begin
			analog_switch_high_r <= wbyte & high_mask;
		end
	end
	// Routing control: acquisition mode bit only
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			routing_control_r <= io_switch_pkg::ROUTING_CONTROL_RST;
		end else if (wr_en && idx == io_switch_pkg::ROUTING_CONTROL_IDX[5:0]) begin
			routing_control_r <= wbyte & io_switch_pkg::ROUTING_CONTROL_MASK;
		end
	end
	// Third-I/O control-mode bits
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			protected_mode_bits_r <= io_switch_pkg::PROTECTED_MODE_RST;
		end else if (wr_en && idx == io_switch_pkg::PROTECTED_MODE_IDX[5:0]) begin
			protected_mode_bits_r <= wbyte;
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (idx)
			io_switch_pkg::THIRD_IO_SWITCH_IDX[5:0]:    rdata_nxt[7:0] = third_io_switch_r;
			io_switch_pkg::IO_GROUP_MODE_IDX[5:0]:      rdata_nxt[7:0] = io_group_mode_r;
			io_switch_pkg::ANALOG_SWITCH_LOW_IDX[5:0]:  rdata_nxt[7:0] = analog_switch_low_r;
			io_switch_pkg::ANALOG_SWITCH_HIGH_IDX[5:0]: rdata_nxt[7:0] = analog_switch_high_r;
			io_switch_pkg::ROUTING_CONTROL_IDX[5:0]:    rdata_nxt[7:0] = routing_control_r;
			io_switch_pkg::PROTECTED_MODE_IDX[5:0]:     rdata_nxt[7:0] = protected_mode_bits_r;
			default:                                    rdata_nxt = 32'h0000_0000;
		endcase
	end
	// Read data registered on the wait cycle, valid while waitrequest is low
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && !ack_r) begin
			AVS_READDATA <= rdata_nxt;
		end
	end

	// Pad mode decoding
	io_switch_pkg::pad_mode_type mode [8]; // Per-I/O mode
	logic [7:0] electrode;                  // Electrode role
	logic [7:0] hyst;                       // Hysteresis off

	third_io_decoder #(.DENSITY(DENSITY)) u_dec (
		.cfg            (cfg.dec),
		.mode           (mode),
		.role_electrode (electrode),
		.hyst_off       (hyst)
	);

	// Registered pad controls
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			THIRD_IO_SWITCH_CLOSED <= 8'h00;
			THIRD_IO_DRIVE_EN      <= 8'h00;
			THIRD_IO_DRIVE_HIGH    <= 8'h00;
			THIRD_IO_TIMER_CTRL    <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				THIRD_IO_SWITCH_CLOSED[i] <= (mode[i] == io_switch_pkg::PAD_FLOAT_CLOSED);
				THIRD_IO_DRIVE_EN[i]      <= (mode[i] == io_switch_pkg::PAD_PP_LOW)
					|| (mode[i] == io_switch_pkg::PAD_PP_HIGH);
				THIRD_IO_DRIVE_HIGH[i]    <= (mode[i] == io_switch_pkg::PAD_PP_HIGH);
				THIRD_IO_TIMER_CTRL[i]    <= (mode[i] == io_switch_pkg::PAD_TIMER);
			end
		end
	end
	// Registered roles, hysteresis and status copies
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			THIRD_IO_ELECTRODE <= 8'h00;
			THIRD_IO_HYST_OFF  <= 8'h00;
			THIRD_IO_PROTECTED <= 8'h00;
			GROUP_MODE_FIELDS  <= 8'h00;
			ACQUISITION_HW     <= 1'b0;
		end else begin
			THIRD_IO_ELECTRODE <= electrode;
			THIRD_IO_HYST_OFF  <= hyst;
			THIRD_IO_PROTECTED <= protected_mode_bits_r;
			GROUP_MODE_FIELDS  <= io_group_mode_r;
			ACQUISITION_HW     <= routing_control_r[io_switch_pkg::ACQUISITION_MODE_BIT];
		end
	end
	// Analog switch outputs, 12 and 13 absent
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ANALOG_SWITCH_CLOSED <= 15'h0000;
		end else begin
			ANALOG_SWITCH_CLOSED <= {analog_switch_high_r[6], 2'b00,
				analog_switch_high_r[3:0], analog_switch_low_r};
		end
	end
endmodule : io_switch_group_control

// *** logic/io_switch_pkg.sv ***
// Package: register map, reset values, field positions and pad mode codes of the switch bank.
// Assumes byte-wide registers on 32-bit Avalon-MM words, byte address = index * 4.
package io_switch_pkg;
	// Register indices
	localparam logic [7:0] THIRD_IO_SWITCH_IDX    = 8'h0b;
	localparam logic [7:0] IO_GROUP_MODE_IDX      = 8'h0c;
	localparam logic [7:0] ANALOG_SWITCH_LOW_IDX  = 8'h0d;
	localparam logic [7:0] ANALOG_SWITCH_HIGH_IDX = 8'h0e;
	localparam logic [7:0] ROUTING_CONTROL_IDX    = 8'h20;
	localparam logic [7:0] PROTECTED_MODE_IDX     = 8'h08;
	// Reset values
	localparam logic [7:0] THIRD_IO_SWITCH_RST    = 8'h00;
	localparam logic [7:0] IO_GROUP_MODE_RST      = 8'hff;
	localparam logic [7:0] ANALOG_SWITCH_LOW_RST  = 8'h00;
	localparam logic [7:0] ANALOG_SWITCH_HIGH_RST = 8'h00;
	localparam logic [7:0] ROUTING_CONTROL_RST    = 8'h00;
	localparam logic [7:0] PROTECTED_MODE_RST     = 8'h00;
	// Field positions
	localparam int ACQUISITION_MODE_BIT = 2;
	localparam int THIRD_IO_FIELD_LSB   = 4;
	localparam int FOURTH_IO_FIELD_LSB  = 6;
	// Implemented bits of the high analog switch register, full and reduced variant
	localparam logic [7:0] ANALOG_HIGH_MASK_FULL = 8'h4f;
	localparam logic [7:0] ANALOG_HIGH_MASK_MED  = 8'h41;
	localparam logic [7:0] ROUTING_CONTROL_MASK  = 8'h04;
	// Density variants
	typedef enum logic [1:0] {
		DENSITY_LOW    = 2'h0,
		DENSITY_MEDIUM = 2'h1,
		DENSITY_MEDPLUS = 2'h2,
		DENSITY_HIGH   = 2'h3
	} density_type;
	// Pad drive modes presented to the pads
	typedef enum logic [2:0] {
		PAD_GPIO      = 3'h0,
		PAD_PP_LOW    = 3'h1,
		PAD_PP_HIGH   = 3'h3,
		PAD_FLOAT_OPEN = 3'h2,
		PAD_FLOAT_CLOSED = 3'h6,
		PAD_TIMER     = 3'h7
	} pad_mode_type;
	// Acquisition roles under hardware management
	localparam logic [1:0] ROLE_SAMPLING  = 2'h0;
	localparam logic [1:0] ROLE_ELECTRODE = 2'h1;
endpackage : io_switch_pkg

// *** logic/switch_cfg_if.sv ***
// Interface: register values shared between the register bank and the pad decoder.
// Assumes one clock domain; carries levels only.
`timescale 1ns/10ps
interface switch_cfg_if;
	logic [7:0] third_io_switch;    // Third-I/O switch bits
	logic [7:0] io_group_mode;      // Four 2-bit mode fields
	logic       acquisition_mode;   // 0 software, 1 hardware
	logic [7:0] protected_mode_bits; // Third-I/O protected-mode bits
	modport regs (output third_io_switch, output io_group_mode,
		output acquisition_mode, output protected_mode_bits);
	modport dec (input third_io_switch, input io_group_mode,
		input acquisition_mode, input protected_mode_bits);
endinterface : switch_cfg_if

// *** logic/third_io_decoder.sv ***
// Pad decoder: turns switch, mode and protection bits into a mode per third I/O.
// Assumes registered inputs on the same clock; output is combinational.
`timescale 1ns/10ps
module third_io_decoder #(
	parameter io_switch_pkg::density_type DENSITY = io_switch_pkg::DENSITY_LOW
) (
	switch_cfg_if.dec                       cfg,
	output io_switch_pkg::pad_mode_type     mode [8],
	output logic [7:0]                      role_electrode,
	output logic [7:0]                      hyst_off
);
	// Decode of one 2-bit field in software-managed acquisition
	function automatic io_switch_pkg::pad_mode_type sw_mode(input logic [1:0] f);
		unique case (f)
			2'b00: sw_mode = io_switch_pkg::PAD_PP_LOW;
			2'b01: sw_mode = io_switch_pkg::PAD_PP_HIGH;
			2'b10: sw_mode = io_switch_pkg::PAD_FLOAT_OPEN;
			2'b11: sw_mode = io_switch_pkg::PAD_FLOAT_CLOSED;
		endcase
	endfunction : sw_mode

	logic [1:0] field; // Third-I/O mode field
	assign field = cfg.io_group_mode[io_switch_pkg::THIRD_IO_FIELD_LSB +: 2];
	// Hardware usage encoding only exists on the low-density variant
	logic hw_acq;
	assign hw_acq = cfg.acquisition_mode && (DENSITY == io_switch_pkg::DENSITY_LOW);

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gen_io
			// Per-I/O mode selection
			always_comb begin
				role_electrode[g] = 1'b0;
				if (!cfg.protected_mode_bits[g]) begin
					mode[g] = cfg.third_io_switch[g] ? io_switch_pkg::PAD_FLOAT_CLOSED
						: io_switch_pkg::PAD_GPIO;
				end else if (!cfg.third_io_switch[g]) begin
					mode[g] = io_switch_pkg::PAD_PP_LOW;
				end else if (hw_acq) begin
					mode[g] = io_switch_pkg::PAD_TIMER;
					role_electrode[g] = (field == io_switch_pkg::ROLE_ELECTRODE);
				end else begin
					mode[g] = sw_mode(field);
				end
				hyst_off[g] = (mode[g] == io_switch_pkg::PAD_FLOAT_CLOSED)
					&& cfg.protected_mode_bits[g];
			end
		end
	endgenerate
endmodule : third_io_decoder
